// >>> prog_model.sv
// external programmer model driving the parallel and serial pins
`timescale 1ns/1ps
module prog_model (
  input wire sys_clk,
  input wire ready_busy_flag_r,
  input wire [7:0] data_out_r,
  input wire miso_r,
  output reg hv_enable,
  output reg prog_reset_n,
  output reg load_strobe_clock,
  output reg cycle_action_select_hi,
  output reg cycle_action_select_lo,
  output reg byte_select_low,
  output reg byte_select_high,
  output reg program_strobe_n,
  output reg output_enable_n,
  output reg page_latch_strobe,
  output reg sck,
  output reg mosi,
  output reg [7:0] pin_d
);
  reg [7:0] res_d;
  event res_ev;
  // idle pin levels
  initial begin
    {hv_enable, prog_reset_n, program_strobe_n, output_enable_n} = 4'hf;
    {cycle_action_select_hi, cycle_action_select_lo} = 2'b11;
    {load_strobe_clock, byte_select_low, byte_select_high, page_latch_strobe, sck, mosi} = 6'h0;
    pin_d = 8'h00;
  end
  task wait_n(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one load strobe; data pins driven inverted afterwards
  task load(input [1:0] act, input bsl, input [7:0] v);
    wait_n(1);
    {cycle_action_select_hi, cycle_action_select_lo} = act;
    byte_select_low = bsl;
    pin_d = v;
    wait_n(4);
    load_strobe_clock = 1'b1;
    wait_n(4);
    load_strobe_clock = 1'b0;
    wait_n(4);
    {cycle_action_select_hi, cycle_action_select_lo} = 2'b11;
    pin_d = ~v;
  endtask
  // write strobe, measures drop delay and busy length
  task wr_pulse(input bsl, input bsh, output integer drop, output integer len);
    integer i;
    drop = 0;
    i = 0;
    wait_n(1);
    byte_select_low = bsl;
    byte_select_high = bsh;
    wait_n(4);
    program_strobe_n = 1'b0;
    while ((drop == 0 || i < 10) && i < 300) begin
      wait_n(1);
      i = i + 1;
      if (i == 10) program_strobe_n = 1'b1;
      if (!ready_busy_flag_r && drop == 0) drop = i;
    end
    len = (drop > 0) ? i - drop : 0;
    while (!ready_busy_flag_r && len < 20000) begin
      wait_n(1);
      len = len + 1;
    end
    byte_select_low = 1'b0;
    byte_select_high = 1'b0;
  endtask
  // read one byte with output enable low
  task rd(input bsl, input bsh);
    wait_n(1);
    byte_select_low = bsl;
    byte_select_high = bsh;
    output_enable_n = 1'b0;
    wait_n(8);
    res_d = data_out_r;
    -> res_ev;
    output_enable_n = 1'b1;
    wait_n(6);
  endtask
  // page latch pulse
  task latch;
    wait_n(1);
    page_latch_strobe = 1'b1;
    wait_n(4);
    page_latch_strobe = 1'b0;
    wait_n(4);
  endtask
  // serial entry with reset pulse after clock low
  task enter_serial;
    wait_n(1);
    hv_enable = 1'b0;
    sck = 1'b0;
    prog_reset_n = 1'b0;
    wait_n(4);
    prog_reset_n = 1'b1;
    wait_n(4);
    prog_reset_n = 1'b0;
    wait_n(20);
  endtask
  // 32-bit frame, 6-cycle phases, sample before rising edge
  task spi(input [31:0] tx, output [31:0] rx);
    integer k;
    for (k = 31; k >= 0; k = k - 1) begin
      mosi = tx[k];
      wait_n(6);
      rx[k] = miso_r;
      sck = 1'b1;
      wait_n(6);
      sck = 1'b0;
    end
    wait_n(6);
  endtask
endmodule

// >>> prog_port.v
// device side of the parallel and serial programming port
`timescale 1ns/1ps
`include "prog_port_defs.vh"
module prog_port #(
  parameter FLASH_AW = 13,
  parameter EE_AW = 9,
  parameter PAGE_AW = 6,
  parameter WR_BUSY_CYC = `T_WLRH_MIN_US * `CLK_MHZ,
  parameter ERASE_BUSY_CYC = `T_WLRH_CE_MIN_US * `CLK_MHZ,
  parameter [7:0] SIG_BYTE0 = 8'h11, // arbitrary
  parameter [7:0] SIG_BYTE1 = 8'h22, // arbitrary
  parameter [7:0] SIG_BYTE2 = 8'h33, // arbitrary
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire sys_clk,
  input wire nrst,
  input wire hv_enable,
  input wire prog_reset_n,
  input wire load_strobe_clock,
  input wire cycle_action_select_hi,
  input wire cycle_action_select_lo,
  input wire byte_select_low,
  input wire byte_select_high,
  input wire program_strobe_n,
  input wire output_enable_n,
  input wire page_latch_strobe,
  input wire [7:0] data_in,
  output reg [7:0] data_out_r,
  output reg data_oe_r,
  output reg ready_busy_flag_r,
  input wire sck,
  input wire mosi,
  output reg miso_r
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WALK = 3'b010;
  localparam ST_WAIT = 3'b100;
  localparam OP_NONE = 3'd0;
  localparam OP_ERASE = 3'd1;
  localparam OP_PAGE = 3'd2;
  localparam OP_EE = 3'd3;
  localparam OP_FUSE = 3'd4;
  localparam OP_LOCK = 3'd5;
  localparam FLASH_WORDS = 1 << FLASH_AW;
  localparam EE_BYTES = 1 << EE_AW;
  localparam PAGE_WORDS = 1 << PAGE_AW;
  localparam WALK_AW = (FLASH_AW > EE_AW) ? FLASH_AW : EE_AW;
  localparam ERASE_LAST = ((FLASH_WORDS > EE_BYTES) ? FLASH_WORDS : EE_BYTES) - 1;
  localparam PAGE_LAST = PAGE_WORDS - 1;

  // lock merge: only programs bits, boot bits frozen in mode 3
  function [7:0] lock_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    begin
      lock_merge = old_v & new_v;
      if (old_v[`LOCK_BASIC_MSB:0] == 2'b00) begin
        lock_merge[`LOCK_BOOT_MSB:`LOCK_BOOT_LSB] = old_v[`LOCK_BOOT_MSB:`LOCK_BOOT_LSB];
      end
    end
  endfunction

  // identification byte by index
  function [7:0] sig_byte;
    input [1:0] idx;
    begin
      if (idx == 2'd0) begin
        sig_byte = SIG_BYTE0;
      end else if (idx == 2'd1) begin
        sig_byte = SIG_BYTE1;
      end else if (idx == 2'd2) begin
        sig_byte = SIG_BYTE2;
      end else begin
        sig_byte = 8'hff;
      end
    end
  endfunction

  // fuse and lock byte by selector: 0 low, 1 high, 2 ext, 3 lock
  function [7:0] fuse_byte;
    input [1:0] sel;
    input [7:0] lo;
    input [7:0] hi;
    input [7:0] ext;
    input [7:0] lk;
    begin
      case (sel)
        2'd0: fuse_byte = lo;
        2'd1: fuse_byte = hi;
        2'd2: fuse_byte = ext;
        default: fuse_byte = lk;
      endcase
    end
  endfunction

  // memories
  reg [15:0] flash_mem [0:FLASH_WORDS-1];
  reg [7:0] ee_mem [0:EE_BYTES-1];
  reg [7:0] pb_lo [0:PAGE_WORDS-1];
  reg [7:0] pb_hi [0:PAGE_WORDS-1];

  // two-flop synchronisers for every pin, third stage for edges
  wire [19:0] pin_raw = {hv_enable, prog_reset_n, sck, mosi, load_strobe_clock, program_strobe_n,
                         output_enable_n, page_latch_strobe, cycle_action_select_hi,
                         cycle_action_select_lo, byte_select_low, byte_select_high, data_in};
  reg [19:0] s1_r;
  reg [19:0] s2_r;
  reg [19:0] s3_r;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      s1_r <= 20'h0;
      s2_r <= 20'h0;
      s3_r <= 20'h0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire hv_s = s2_r[19];
  wire rstp_s = s2_r[18];
  wire mosi_s = s2_r[16];
  wire oen_s = s2_r[13];
  wire [1:0] act_s = s2_r[11:10];
  wire bs1_s = s2_r[9];
  wire bs2_s = s2_r[8];
  wire [7:0] din_s = s2_r[7:0];
  wire sck_rise = s2_r[17] & ~s3_r[17];
  wire sck_fall = ~s2_r[17] & s3_r[17];
  wire lsc_rise = s2_r[15] & ~s3_r[15];
  wire wr_fall = ~s2_r[14] & s3_r[14];
  wire pl_rise = s2_r[12] & ~s3_r[12];
  wire par_on = hv_s;
  wire ser_on = ~hv_s & ~rstp_s;

  // fuse and lock bytes, written by the busy sequencer
  reg [7:0] fuse_lo_r;
  reg [7:0] fuse_hi_r;
  reg [7:0] fuse_ext_r;
  reg [7:0] lock_r;

  // parallel load registers
  reg [7:0] cmd_r;
  reg [7:0] addr_lo_r;
  reg [7:0] addr_hi_r;
  reg [7:0] dat_lo_r;
  reg [7:0] dat_hi_r;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      cmd_r <= 8'h00;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      dat_lo_r <= 8'h00;
      dat_hi_r <= 8'h00;
    end else if (par_on && lsc_rise && ready_busy_flag_r) begin
      if (act_s == `ACT_CMD) begin
        cmd_r <= din_s;
      end else if (act_s == `ACT_ADDR) begin
        if (bs1_s) begin
          addr_hi_r <= din_s;
        end else begin
          addr_lo_r <= din_s;
        end
      end else if (act_s == `ACT_DATA) begin
        if (bs1_s) begin
          dat_hi_r <= din_s;
        end else begin
          dat_lo_r <= din_s;
        end
      end
    end
  end
  wire [15:0] par_addr = {addr_hi_r, addr_lo_r};
  wire [FLASH_AW-1:0] par_waddr = par_addr[FLASH_AW-1:0];
  wire [EE_AW-1:0] par_eaddr = par_addr[EE_AW-1:0];

  // serial shift engine
  reg [4:0] bit_cnt_r;
  reg [31:0] rx_r;
  reg [7:0] tx_r;
  reg load_pend_r;
  reg ser_en_r;
  wire [7:0] b1 = rx_r[23:16];
  wire [7:0] b2 = rx_r[15:8];
  wire [7:0] b3 = rx_r[7:0];
  wire [15:0] ser_addr = {b2, b3};
  wire [FLASH_AW-1:0] ser_waddr = ser_addr[FLASH_AW-1:0];
  wire [EE_AW-1:0] ser_eaddr = ser_addr[EE_AW-1:0];
  reg [7:0] resp;
  // answer byte, chosen once three bytes are in
  always @* begin
    resp = 8'h00;
    if (b1 == `SI_POLL) begin
      resp = {7'h0, ~ready_busy_flag_r};
    end else if (b1 == `SI_RD_HI) begin
      resp = flash_mem[ser_waddr][15:8];
    end else if (b1 == `SI_RD_LO) begin
      resp = flash_mem[ser_waddr][7:0];
    end else if (b1 == `SI_RD_EE) begin
      resp = ee_mem[ser_eaddr];
    end else if (b1 == `SI_RD_LOCK) begin
      resp = fuse_byte({~b2[3], 1'b1}, fuse_lo_r, fuse_hi_r, fuse_ext_r, lock_r);
    end else if (b1 == `SI_RD_FUSE) begin
      resp = fuse_byte({b2[3], 1'b0}, fuse_lo_r, fuse_hi_r, fuse_ext_r, lock_r);
    end else if (b1 == `SI_RD_SIG) begin
      resp = sig_byte(b3[1:0]);
    end else if (b1 == `SI_RD_CAL) begin
      resp = CAL_BYTE;
    end
  end
  wire word_done = ser_on && sck_rise && (bit_cnt_r == 5'd31);
  always @(posedge sys_clk) begin
    if (!nrst || !ser_on) begin
      bit_cnt_r <= 5'd0;
      rx_r <= 32'h0;
      tx_r <= 8'h00;
      load_pend_r <= 1'b0;
      miso_r <= 1'b0;
    end else begin
      if (sck_rise) begin
        rx_r <= {rx_r[30:0], mosi_s};
        bit_cnt_r <= bit_cnt_r + 5'd1;
        load_pend_r <= (bit_cnt_r[2:0] == 3'd7);
      end
      if (sck_fall) begin
        if (load_pend_r) begin
          // echo last byte, or the answer before byte four
          load_pend_r <= 1'b0;
          if (bit_cnt_r == 5'd24) begin
            miso_r <= resp[7];
            tx_r <= {resp[6:0], 1'b0};
          end else begin
            miso_r <= rx_r[7];
            tx_r <= {rx_r[6:0], 1'b0};
          end
        end else begin
          miso_r <= tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // programming enable: needs prefix and 0x53 in sync
  always @(posedge sys_clk) begin
    if (!nrst || !ser_on) begin
      ser_en_r <= 1'b0;
    end else if (word_done && rx_r[30:15] == {`SI_PREFIX, `SI_ENABLE}) begin
      ser_en_r <= 1'b1;
    end
  end
  // full instruction as it will stand after the last bit
  wire [31:0] ins = {rx_r[30:0], mosi_s};
  wire [7:0] i1 = ins[31:24];
  wire [7:0] i2 = ins[23:16];
  wire [7:0] i3 = ins[15:8];
  wire [7:0] i4 = ins[7:0];
  wire [15:0] ins_addr = {i2, i3};

  // start selection from either mode
  reg start;
  reg [2:0] st_op;
  reg [1:0] st_sel;
  reg [FLASH_AW-1:0] st_addr;
  reg [EE_AW-1:0] st_eaddr;
  reg [7:0] st_data;
  always @* begin
    start = 1'b0;
    st_op = OP_NONE;
    st_sel = 2'd0;
    st_addr = par_waddr;
    st_eaddr = par_eaddr;
    st_data = dat_lo_r;
    if (par_on && wr_fall && ready_busy_flag_r) begin
      start = 1'b1;
      if (cmd_r == `CMD_ERASE) begin
        st_op = OP_ERASE;
      end else if (cmd_r == `CMD_WR_FUSE) begin
        st_op = OP_FUSE;
        st_sel = {bs2_s, bs1_s & ~bs2_s};
      end else if (cmd_r == `CMD_WR_LOCK) begin
        st_op = OP_LOCK;
      end else if (cmd_r == `CMD_WR_FLASH) begin
        st_op = OP_PAGE;
      end else if (cmd_r == `CMD_WR_EE) begin
        st_op = OP_EE;
      end else begin
        start = 1'b0;
      end
    end else if (word_done && ser_en_r && ready_busy_flag_r) begin
      start = 1'b1;
      st_addr = ins_addr[FLASH_AW-1:0];
      st_eaddr = ins_addr[EE_AW-1:0];
      st_data = i4;
      if (i1 == `SI_PREFIX && i2 == `SI_ERASE) begin
        st_op = OP_ERASE;
      end else if (i1 == `SI_PREFIX && i2 == `SI_WR_LOCK) begin
        st_op = OP_LOCK;
      end else if (i1 == `SI_PREFIX && i2 == `SI_WR_FUSE_LO) begin
        st_op = OP_FUSE;
      end else if (i1 == `SI_PREFIX && i2 == `SI_WR_FUSE_HI) begin
        st_op = OP_FUSE;
        st_sel = 2'd1;
      end else if (i1 == `SI_PREFIX && i2 == `SI_WR_FUSE_EXT) begin
        st_op = OP_FUSE;
        st_sel = 2'd2;
      end else if (i1 == `SI_WR_PAGE) begin
        st_op = OP_PAGE;
      end else if (i1 == `SI_WR_EE) begin
        st_op = OP_EE;
      end else begin
        start = 1'b0;
      end
    end
  end

  // busy sequencer
  reg [2:0] state_r;
  reg [2:0] op_r;
  reg [21:0] busy_cnt_r;
  reg [WALK_AW-1:0] walk_r;
  reg [FLASH_AW-1:0] op_addr_r;
  // erase walks whichever array is larger, page copy one page
  wire [WALK_AW-1:0] walk_last = (op_r == OP_ERASE) ? ERASE_LAST[WALK_AW-1:0] : PAGE_LAST[WALK_AW-1:0];
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      op_r <= OP_NONE;
      busy_cnt_r <= 22'd0;
      walk_r <= {WALK_AW{1'b0}};
      op_addr_r <= {FLASH_AW{1'b0}};
      ready_busy_flag_r <= 1'b1;
      fuse_lo_r <= `FUSE_LO_RST;
      fuse_hi_r <= `FUSE_HI_RST;
      fuse_ext_r <= `FUSE_EXT_RST;
      lock_r <= `LOCK_RST;
    end else begin
      if (busy_cnt_r != 22'd0) begin
        busy_cnt_r <= busy_cnt_r - 22'd1;
      end
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            ready_busy_flag_r <= 1'b0;
            op_r <= st_op;
            op_addr_r <= st_addr;
            walk_r <= {WALK_AW{1'b0}};
            if (st_op == OP_ERASE) begin
              busy_cnt_r <= ERASE_BUSY_CYC[21:0];
            end else begin
              busy_cnt_r <= WR_BUSY_CYC[21:0];
            end
            if (st_op == OP_FUSE && st_sel == 2'd0) begin
              fuse_lo_r <= st_data;
            end
            if (st_op == OP_FUSE && st_sel == 2'd1) begin
              fuse_hi_r <= st_data;
            end
            if (st_op == OP_FUSE && st_sel == 2'd2) begin
              fuse_ext_r <= st_data;
            end
            if (st_op == OP_LOCK) begin
              lock_r <= lock_merge(lock_r, st_data);
            end
            if (st_op == OP_ERASE || st_op == OP_PAGE) begin
              state_r <= ST_WALK;
            end else begin
              state_r <= ST_WAIT;
            end
          end
        end
        ST_WALK: begin
          walk_r <= walk_r + 1'b1;
          if (walk_r == walk_last) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (busy_cnt_r <= 22'd1) begin
            ready_busy_flag_r <= 1'b1;
            state_r <= ST_IDLE;
            if (op_r == OP_ERASE) begin
              lock_r <= `LOCK_RST;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // memory array updates: erase walk, page copy, byte writes, page buffer
  always @(posedge sys_clk) begin
    if (state_r == ST_WALK && op_r == OP_ERASE) begin
      if (walk_r < FLASH_WORDS) begin
        flash_mem[walk_r[FLASH_AW-1:0]] <= 16'hffff;
      end
      if (walk_r < EE_BYTES) begin
        ee_mem[walk_r[EE_AW-1:0]] <= 8'hff;
      end
    end
    if (state_r == ST_WALK && op_r == OP_PAGE) begin
      flash_mem[{op_addr_r[FLASH_AW-1:PAGE_AW], walk_r[PAGE_AW-1:0]}] <=
        {pb_hi[walk_r[PAGE_AW-1:0]], pb_lo[walk_r[PAGE_AW-1:0]]};
    end
    if (state_r == ST_IDLE && start && st_op == OP_EE) begin
      ee_mem[st_eaddr] <= st_data;
    end
    if (par_on && pl_rise && ready_busy_flag_r) begin
      pb_lo[addr_lo_r[PAGE_AW-1:0]] <= dat_lo_r;
      pb_hi[addr_lo_r[PAGE_AW-1:0]] <= dat_hi_r;
    end
    if (word_done && ser_en_r && i1 == `SI_LD_LO) begin
      pb_lo[i3[PAGE_AW-1:0]] <= i4;
    end
    if (word_done && ser_en_r && i1 == `SI_LD_HI) begin
      pb_hi[i3[PAGE_AW-1:0]] <= i4;
    end
  end

  // parallel read path, driven only while OE is low
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'hff;
    if (cmd_r == `CMD_RD_EE) begin
      rd_byte = ee_mem[par_eaddr];
    end else if (cmd_r == `CMD_RD_FLASH) begin
      rd_byte = bs1_s ? flash_mem[par_waddr][15:8] : flash_mem[par_waddr][7:0];
    end else if (cmd_r == `CMD_RD_FUSE) begin
      rd_byte = fuse_byte({bs2_s ^ bs1_s, bs1_s}, fuse_lo_r, fuse_hi_r, fuse_ext_r, lock_r);
    end else if (cmd_r == `CMD_RD_SIG) begin
      rd_byte = bs1_s ? CAL_BYTE : sig_byte(addr_lo_r[1:0]);
    end
  end
  always @(posedge sys_clk) begin
    if (!nrst) begin
      data_out_r <= 8'h00;
      data_oe_r <= 1'b0;
    end else begin
      data_out_r <= rd_byte;
      data_oe_r <= par_on & ~oen_s;
    end
  end
endmodule

// >>> prog_port_defs.vh
// constants for the external programming port
`ifndef PROG_PORT_DEFS_VH
`define PROG_PORT_DEFS_VH
// parallel commands
`define CMD_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_LOCK 8'h20
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EE 8'h11
`define CMD_RD_SIG 8'h08
`define CMD_RD_FUSE 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EE 8'h03
// cycle action codes
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
// serial instruction bytes
`define SI_PREFIX 8'hac
`define SI_ENABLE 8'h53
`define SI_ERASE 8'h80
`define SI_WR_LOCK 8'he0
`define SI_WR_FUSE_LO 8'ha0
`define SI_WR_FUSE_HI 8'ha8
`define SI_WR_FUSE_EXT 8'ha4
`define SI_POLL 8'hf0
`define SI_LD_LO 8'h40
`define SI_LD_HI 8'h48
`define SI_WR_PAGE 8'h4c
`define SI_RD_HI 8'h28
`define SI_RD_LO 8'h20
`define SI_RD_EE 8'ha0
`define SI_WR_EE 8'hc0
`define SI_RD_LOCK 8'h58
`define SI_RD_SIG 8'h30
`define SI_RD_FUSE 8'h50
`define SI_RD_CAL 8'h38
`define SI_SEL_HI 8'h08
// field positions and reset values
`define LOCK_BASIC_MSB 1
`define LOCK_BOOT_LSB 2
`define LOCK_BOOT_MSB 5
`define FUSE_LO_RST 8'hff
`define FUSE_HI_RST 8'hff
`define FUSE_EXT_RST 8'hff
`define LOCK_RST 8'hff
// timing
`define CLK_MHZ 250
`define T_WLRH_MIN_US 3700
`define T_WLRH_CE_MIN_US 7500
`endif

// >>> prog_port_props.sv
// assertion checker for the programming port outputs
`timescale 1ns/1ps
module prog_port_props #(
  parameter FLASH_AW = 13,
  parameter WR_BUSY_CYC = 925000,
  parameter ERASE_BUSY_CYC = 1875000
) (
  input wire sys_clk,
  input wire nrst,
  input wire hv_enable,
  input wire prog_reset_n,
  input wire program_strobe_n,
  input wire output_enable_n,
  input wire sck,
  input wire [7:0] data_out_r,
  input wire data_oe_r,
  input wire ready_busy_flag_r,
  input wire miso_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // length of the current busy window
  reg [31:0] busy_cnt_r;
  always @(posedge sys_clk) begin
    if (!nrst || ready_busy_flag_r) busy_cnt_r <= 32'h0;
    else busy_cnt_r <= busy_cnt_r + 32'h1;
  end
  reset_vals_a: assert property (@(posedge sys_clk) disable iff (1'b0) !nrst |=>
    ready_busy_flag_r && !data_oe_r && data_out_r == 8'h00 && !miso_r) else $error("bad reset outputs");
  busy_min_a: assert property ($rose(ready_busy_flag_r) |-> busy_cnt_r >= WR_BUSY_CYC - 8)
    else $error("busy window too short");
  busy_max_a: assert property (!ready_busy_flag_r |-> busy_cnt_r < ERASE_BUSY_CYC + (1 << FLASH_AW) + 64)
    else $error("busy window too long");
  busy_cause_a: assert property ($fell(ready_busy_flag_r) && hv_enable |-> !$past(program_strobe_n, 2))
    else $error("busy without write strobe");
  oe_drive_a: assert property ((hv_enable && !output_enable_n) [*5] |-> data_oe_r)
    else $error("data pins not driven");
  oe_release_a: assert property ((output_enable_n || !hv_enable) [*5] |-> !data_oe_r)
    else $error("data pins not released");
  oe_cause_a: assert property ($rose(data_oe_r) |-> !$past(output_enable_n, 3))
    else $error("drive without output enable");
  miso_edge_a: assert property ($changed(miso_r) && !hv_enable && !prog_reset_n |-> !sck)
    else $error("serial out moved while clock high");
endmodule
bind prog_port prog_port_props #(.FLASH_AW(FLASH_AW), .WR_BUSY_CYC(WR_BUSY_CYC),
  .ERASE_BUSY_CYC(ERASE_BUSY_CYC)) i_prog_port_props (.sys_clk(sys_clk), .nrst(nrst),
  .hv_enable(hv_enable), .prog_reset_n(prog_reset_n), .program_strobe_n(program_strobe_n),
  .output_enable_n(output_enable_n), .sck(sck), .data_out_r(data_out_r), .data_oe_r(data_oe_r),
  .ready_busy_flag_r(ready_busy_flag_r), .miso_r(miso_r));

// >>> testbench.sv
// self-checking bench for the programming port
`timescale 1ns/1ps
module testbench;
  localparam FAW = 8;
  localparam WRC = 800;
  localparam ERC = 1200;
  localparam [23:0] SIGS = 24'h7c6b5a; // arbitrary
  localparam [7:0] CAL = 8'h9d; // arbitrary
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  wire hv_enable, prog_reset_n, load_strobe_clock, cycle_action_select_hi, cycle_action_select_lo;
  wire byte_select_low, byte_select_high, program_strobe_n, output_enable_n, page_latch_strobe;
  wire sck, mosi, data_oe_r, ready_busy_flag_r, miso_r;
  wire [7:0] data_in, data_out_r, pin_d;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer dr, ln, k;
  reg [7:0] exp_q[$];
  reg [7:0] d, lo, hi, ex, e;
  reg [8:0] a;
  reg [31:0] rr, rx;
  assign data_in = data_oe_r ? data_out_r : pin_d;
  prog_port #(.FLASH_AW(FAW), .WR_BUSY_CYC(WRC), .ERASE_BUSY_CYC(ERC), .SIG_BYTE0(SIGS[7:0]),
    .SIG_BYTE1(SIGS[15:8]), .SIG_BYTE2(SIGS[23:16]), .CAL_BYTE(CAL)) i_prog_port (.sys_clk(sys_clk),
    .nrst(nrst), .hv_enable(hv_enable), .prog_reset_n(prog_reset_n), .load_strobe_clock(load_strobe_clock),
    .cycle_action_select_hi(cycle_action_select_hi), .cycle_action_select_lo(cycle_action_select_lo),
    .byte_select_low(byte_select_low), .byte_select_high(byte_select_high), .program_strobe_n(program_strobe_n),
    .output_enable_n(output_enable_n), .page_latch_strobe(page_latch_strobe), .data_in(data_in),
    .data_out_r(data_out_r), .data_oe_r(data_oe_r), .ready_busy_flag_r(ready_busy_flag_r), .sck(sck),
    .mosi(mosi), .miso_r(miso_r));
  prog_model i_prog_model (.sys_clk(sys_clk), .ready_busy_flag_r(ready_busy_flag_r), .data_out_r(data_out_r),
    .miso_r(miso_r), .hv_enable(hv_enable), .prog_reset_n(prog_reset_n), .load_strobe_clock(load_strobe_clock),
    .cycle_action_select_hi(cycle_action_select_hi), .cycle_action_select_lo(cycle_action_select_lo),
    .byte_select_low(byte_select_low), .byte_select_high(byte_select_high), .program_strobe_n(program_strobe_n),
    .output_enable_n(output_enable_n), .page_latch_strobe(page_latch_strobe), .sck(sck), .mosi(mosi),
    .pin_d(pin_d));
  // 250 MHz clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input logic ok, input string msg);
    samples_checked = samples_checked + 1;
    if (ok !== 1'b1) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  // compare each read result with the oldest note
  initial begin
    forever begin
      @(i_prog_model.res_ev);
      if (exp_q.size() == 0) chk(1'b0, "unexpected read");
      else begin
        e = exp_q.pop_front();
        chk(i_prog_model.res_d === e, "read data");
      end
    end
  end
  task pcmd(input [7:0] c);
    i_prog_model.load(2'b10, 1'b0, c);
  endtask
  task rd_exp(input bsl, input bsh, input [7:0] v);
    exp_q.push_back(v);
    i_prog_model.rd(bsl, bsh);
  endtask
  task wr(input bsl, input bsh, input integer minc);
    i_prog_model.wr_pulse(bsl, bsh, dr, ln);
    chk(dr > 0 && dr <= 250, "busy did not drop");
    chk(dr + ln >= minc, "busy too short");
  endtask
  task sx(input [31:0] tx);
    i_prog_model.spi(tx, rx);
  endtask
  task poll_done;
    k = 0;
    sx(32'hf0000000);
    while (rx[0] !== 1'b0 && k < 20) begin
      sx(32'hf0000000);
      k = k + 1;
    end
    chk(rx[0] === 1'b0, "still busy");
  endtask
  // main sequence
  initial begin
    rr = $urandom(32'he41a);
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(ready_busy_flag_r === 1'b1, "not ready after reset");
    rr = $urandom;
    a = rr[8:0];
    d = rr[16:9];
    lo = rr[24:17];
    rr = $urandom;
    hi = rr[7:0];
    ex = rr[15:8];
    pcmd(8'h80);
    wr(1'b0, 1'b0, ERC);
    pcmd(8'h03);
    i_prog_model.load(2'b00, 1'b1, {7'h0, a[8]});
    i_prog_model.load(2'b00, 1'b0, a[7:0]);
    rd_exp(1'b0, 1'b0, 8'hff);
    pcmd(8'h11);
    i_prog_model.load(2'b01, 1'b0, d);
    wr(1'b0, 1'b0, WRC);
    pcmd(8'h03);
    rd_exp(1'b0, 1'b0, d);
    pcmd(8'h10);
    i_prog_model.load(2'b00, 1'b1, 8'h00);
    i_prog_model.load(2'b00, 1'b0, a[7:0]);
    i_prog_model.load(2'b01, 1'b0, lo);
    i_prog_model.load(2'b01, 1'b1, hi);
    i_prog_model.latch();
    wr(1'b0, 1'b0, WRC);
    pcmd(8'h02);
    rd_exp(1'b0, 1'b0, lo);
    rd_exp(1'b1, 1'b0, hi);
    pcmd(8'h40);
    i_prog_model.load(2'b01, 1'b0, lo);
    wr(1'b0, 1'b0, WRC);
    i_prog_model.load(2'b01, 1'b0, hi);
    wr(1'b1, 1'b0, WRC);
    i_prog_model.load(2'b01, 1'b0, ex);
    wr(1'b0, 1'b1, WRC);
    pcmd(8'h20);
    i_prog_model.load(2'b01, 1'b0, 8'hfc);
    wr(1'b0, 1'b0, WRC);
    i_prog_model.load(2'b01, 1'b0, 8'h03);
    wr(1'b0, 1'b0, WRC);
    i_prog_model.load(2'b01, 1'b0, 8'hff);
    wr(1'b0, 1'b0, WRC);
    pcmd(8'h04);
    rd_exp(1'b0, 1'b0, lo);
    rd_exp(1'b1, 1'b1, hi);
    rd_exp(1'b0, 1'b1, ex);
    rd_exp(1'b1, 1'b0, 8'h3c);
    pcmd(8'h80);
    wr(1'b0, 1'b0, ERC);
    pcmd(8'h04);
    rd_exp(1'b1, 1'b0, 8'hff);
    pcmd(8'h03);
    rd_exp(1'b0, 1'b0, 8'hff);
    pcmd(8'h08);
    for (k = 0; k < 3; k = k + 1) begin
      i_prog_model.load(2'b00, 1'b0, k[7:0]);
      rd_exp(1'b0, 1'b0, SIGS[8*k +: 8]);
    end
    i_prog_model.load(2'b00, 1'b0, 8'h00);
    rd_exp(1'b1, 1'b0, CAL);
    i_prog_model.enter_serial();
    sx({8'hc0, 7'h0, a, 8'h5a});
    sx(32'hac530000);
    chk(rx[15:8] === 8'h53, "no enable echo");
    sx({8'ha0, 7'h0, a, 8'h00});
    chk(rx[7:0] === 8'hff, "write before enable taken");
    sx({8'hc0, 7'h0, a, d});
    sx(32'hf0000000);
    chk(rx[0] === 1'b1, "busy not reported");
    poll_done();
    sx({8'hc0, 7'h0, a, ~d});
    poll_done();
    sx({8'ha0, 7'h0, a, 8'h00});
    chk(rx[7:0] === ~d, "serial write without erase");
    chk(exp_q.size() == 0, "reads missing");
    report_and_stop;
  end
endmodule
